/* inc/bdsp_pkg.sv */
// Shared constants for the two-word burst double-rate memory port
package bdsp_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int DATA_W = 18;
    localparam int BURST_LEN = 2;
    localparam int LINE_W = DATA_W * BURST_LEN;
    localparam int ADDR_W = 8;
    localparam int DEPTH = 1 << ADDR_W;

    // ==========================================================
    // Read latency in clock cycles per select level
    // ==========================================================
    localparam int LAT_PLL_CYC = 2;
    localparam int LAT_LEGACY_CYC = 1;

    // ==========================================================
    // Control pin levels
    // ==========================================================
    localparam logic LOAD_ACTIVE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic LAT_SEL_PLL = 1'b1;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DATA_W-1:0] DQ_IDLE = '0;
    localparam logic [LINE_W-1:0] LINE_IDLE = '0;
    localparam logic [ADDR_W-1:0] ADDR_IDLE = '0;

    // Echo clock halves: bit 0 true echo, bit 1 complementary echo
    localparam logic [1:0] ECHO_AFTER_K = 2'h1;
    localparam logic [1:0] ECHO_AFTER_KN = 2'h2;
    localparam logic [1:0] ECHO_IDLE = 2'h0;

endpackage : bdsp_pkg

/* hdl/bdsp_mem.sv */
// Burst line storage with clocked write and registered read
`timescale 1ns/1ps

module bdsp_mem (
    input wire logic i_wclk,
    input wire logic i_we,
    input wire logic [bdsp_pkg::ADDR_W-1:0] i_waddr,
    input wire logic [bdsp_pkg::LINE_W-1:0] i_wdata,
    input wire logic i_rclk,
    input wire logic i_re,
    input wire logic [bdsp_pkg::ADDR_W-1:0] i_raddr,
    output logic [bdsp_pkg::LINE_W-1:0] o_rdata
);

    logic [bdsp_pkg::LINE_W-1:0] mem_reg [bdsp_pkg::DEPTH];

    always_ff @(posedge i_wclk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // Read data always leaves through a register
    always_ff @(posedge i_rclk) begin
        if (i_re) begin
            o_rdata <= mem_reg[i_raddr];
        end
    end

endmodule : bdsp_mem

/* hdl/bdsp_port.sv */
// Two-word burst double-rate memory port, device side
// Behaviour
// - One address per two-word transfer, taken only on alternate true-clock rising edges.
// - Write words sampled on true-clock and complementary-clock rising edges, one each.
// - Read words launched on true-clock and complementary-clock rising edges, one each.
// - Each address holds a pair of words, moved as a sequential burst.
// - Latency select high: read data two full cycles after address capture.
// - Latency select low: read data one cycle after address capture.
// - Read-valid flag asserted while read words sit on the data pins.
// - Read data edge-aligned with the echo clock pair.
// - All synchronous inputs registered by the input clocks before use.
// - Data outputs driven from output registers, never straight from the array.
// - Writes finish by internal self-timing, no write strobe needed.
// - Only rising edges of both input clocks are used.
`timescale 1ns/1ps

module bdsp_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_k_clk,
    input wire logic i_kn_clk,
    input wire logic i_load_n,
    input wire logic i_read_nwrite,
    input wire logic [bdsp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [bdsp_pkg::DATA_W-1:0] i_dq,
    input wire logic i_pll_latency_select,
    output logic [bdsp_pkg::DATA_W-1:0] o_dq_k,
    output logic [bdsp_pkg::DATA_W-1:0] o_dq_kn,
    output logic o_dq_oe_k,
    output logic o_dq_oe_kn,
    output logic o_read_valid_flag_k,
    output logic o_read_valid_flag_kn,
    output logic [1:0] o_echo_clock_pair_k,
    output logic [1:0] o_echo_clock_pair_kn,
    output logic o_write_done,
    output logic o_read_done
);

    // ==========================================================
    // Link reset, taken from the system clock domain
    // ==========================================================
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic link_rst;

    always_ff @(posedge i_k_clk) begin
        rst_meta_reg <= ~i_rst_n;
        rst_sync_reg <= rst_meta_reg;
    end

    assign link_rst = rst_sync_reg;

    // ==========================================================
    // Latency select pin synchroniser
    // ==========================================================
    logic lat_meta_reg;
    logic lat_sel_reg;

    always_ff @(posedge i_k_clk) begin
        lat_meta_reg <= i_pll_latency_select;
        lat_sel_reg <= lat_meta_reg;
    end

    // ==========================================================
    // Input registers on the true clock
    // ==========================================================
    logic load_pin_reg;
    logic rw_pin_reg;
    logic [bdsp_pkg::ADDR_W-1:0] addr_pin_reg;
    logic [bdsp_pkg::DATA_W-1:0] dq_k_pin_reg;

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            load_pin_reg <= 1'b0;
            rw_pin_reg <= bdsp_pkg::RW_READ;
            addr_pin_reg <= bdsp_pkg::ADDR_IDLE;
            dq_k_pin_reg <= bdsp_pkg::DQ_IDLE;
        end else begin
            load_pin_reg <= (i_load_n == bdsp_pkg::LOAD_ACTIVE);
            rw_pin_reg <= i_read_nwrite;
            addr_pin_reg <= i_addr;
            dq_k_pin_reg <= i_dq;
        end
    end

    // ==========================================================
    // Input register on the complementary clock
    // ==========================================================
    logic [bdsp_pkg::DATA_W-1:0] dq_kn_pin_reg;

    always_ff @(posedge i_kn_clk) begin
        if (link_rst) begin
            dq_kn_pin_reg <= bdsp_pkg::DQ_IDLE;
        end else begin
            dq_kn_pin_reg <= i_dq;
        end
    end

    // ==========================================================
    // Command acceptance on alternate edges
    // ==========================================================
    logic acc_reg;
    logic acc;
    logic acc_read;
    logic acc_write;

    // A load right after an accepted one is ignored
    assign acc = load_pin_reg & ~acc_reg;
    assign acc_read = acc & (rw_pin_reg == bdsp_pkg::RW_READ);
    assign acc_write = acc & (rw_pin_reg != bdsp_pkg::RW_READ);

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            acc_reg <= 1'b0;
        end else begin
            acc_reg <= acc;
        end
    end

    // ==========================================================
    // Self-timed write: word 0 at next true edge, word 1 half later
    // ==========================================================
    logic wr_pend_reg;
    logic [bdsp_pkg::ADDR_W-1:0] wr_addr_reg;
    logic wr_commit;
    logic [bdsp_pkg::LINE_W-1:0] wr_line;

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= bdsp_pkg::ADDR_IDLE;
        end else begin
            wr_pend_reg <= acc_write;
            if (acc_write) begin
                wr_addr_reg <= addr_pin_reg;
            end
        end
    end

    assign wr_commit = wr_pend_reg;
    assign wr_line = {dq_kn_pin_reg, dq_k_pin_reg};

    // ==========================================================
    // Line storage; read issued on the complementary edge
    // ==========================================================
    logic [bdsp_pkg::LINE_W-1:0] rd_line;

    bdsp_mem u_mem (
        .i_wclk(i_k_clk),
        .i_we(wr_commit),
        .i_waddr(wr_addr_reg),
        .i_wdata(wr_line),
        .i_rclk(i_kn_clk),
        .i_re(acc_read),
        .i_raddr(addr_pin_reg),
        .o_rdata(rd_line)
    );

    // ==========================================================
    // Read pipeline on the true clock
    // ==========================================================
    logic rd_s1_reg;
    logic rd_s2_reg;
    logic [bdsp_pkg::LINE_W-1:0] hold_reg;
    logic lat_pll;

    assign lat_pll = (lat_sel_reg == bdsp_pkg::LAT_SEL_PLL);

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            rd_s1_reg <= 1'b0;
            rd_s2_reg <= 1'b0;
            hold_reg <= bdsp_pkg::LINE_IDLE;
        end else begin
            rd_s1_reg <= acc_read;
            rd_s2_reg <= rd_s1_reg;
            if (acc_read) begin
                hold_reg <= rd_line;
            end
        end
    end

    // ==========================================================
    // Output registers, first burst word on the true clock
    // ==========================================================
    logic out_k_valid;
    logic [bdsp_pkg::DATA_W-1:0] out_k_word;

    always_comb begin
        if (lat_pll) begin
            out_k_valid = rd_s1_reg;
            out_k_word = hold_reg[bdsp_pkg::DATA_W-1:0];
        end else begin
            out_k_valid = acc_read;
            out_k_word = rd_line[bdsp_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            o_dq_k <= bdsp_pkg::DQ_IDLE;
            o_dq_oe_k <= 1'b0;
            o_read_valid_flag_k <= 1'b0;
            o_echo_clock_pair_k <= bdsp_pkg::ECHO_IDLE;
        end else begin
            o_dq_k <= out_k_valid ? out_k_word : bdsp_pkg::DQ_IDLE;
            o_dq_oe_k <= out_k_valid;
            o_read_valid_flag_k <= out_k_valid;
            o_echo_clock_pair_k <= bdsp_pkg::ECHO_AFTER_K;
        end
    end

    // ==========================================================
    // Output registers, second burst word on the complementary clock
    // ==========================================================
    logic out_kn_valid;
    logic [bdsp_pkg::DATA_W-1:0] out_kn_word;

    always_comb begin
        if (lat_pll) begin
            out_kn_valid = rd_s2_reg;
            out_kn_word = hold_reg[bdsp_pkg::LINE_W-1:bdsp_pkg::DATA_W];
        end else begin
            out_kn_valid = rd_s1_reg;
            out_kn_word = rd_line[bdsp_pkg::LINE_W-1:bdsp_pkg::DATA_W];
        end
    end

    always_ff @(posedge i_kn_clk) begin
        if (link_rst) begin
            o_dq_kn <= bdsp_pkg::DQ_IDLE;
            o_dq_oe_kn <= 1'b0;
            o_read_valid_flag_kn <= 1'b0;
            o_echo_clock_pair_kn <= bdsp_pkg::ECHO_IDLE;
        end else begin
            o_dq_kn <= out_kn_valid ? out_kn_word : bdsp_pkg::DQ_IDLE;
            o_dq_oe_kn <= out_kn_valid;
            o_read_valid_flag_kn <= out_kn_valid;
            o_echo_clock_pair_kn <= bdsp_pkg::ECHO_AFTER_KN;
        end
    end

    // ==========================================================
    // Completion events toward the system clock
    // ==========================================================
    logic wr_tgl_reg;
    logic rd_tgl_reg;

    always_ff @(posedge i_k_clk) begin
        if (link_rst) begin
            wr_tgl_reg <= 1'b0;
            rd_tgl_reg <= 1'b0;
        end else begin
            if (wr_commit) begin
                wr_tgl_reg <= ~wr_tgl_reg;
            end
            if (acc_read) begin
                rd_tgl_reg <= ~rd_tgl_reg;
            end
        end
    end

    logic [2:0] wr_sync_reg;
    logic [2:0] rd_sync_reg;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_sync_reg <= 3'h0;
            rd_sync_reg <= 3'h0;
        end else begin
            wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_write_done <= 1'b0;
            o_read_done <= 1'b0;
        end else begin
            o_write_done <= wr_sync_reg[2] ^ wr_sync_reg[1];
            o_read_done <= rd_sync_reg[2] ^ rd_sync_reg[1];
        end
    end

endmodule : bdsp_port

/* tb/bdsp_ctrl_model.sv */
// Controller model for the link side of the burst memory port
`timescale 1ns/1ps

module bdsp_ctrl_model (
    input wire logic i_k_clk,
    output logic o_load_n,
    output logic o_read_nwrite,
    output logic [bdsp_pkg::ADDR_W-1:0] o_addr,
    output logic [bdsp_pkg::DATA_W-1:0] o_dq
);
    initial begin
        o_load_n = 1'b1;
        o_read_nwrite = 1'b1;
        o_addr = '0;
        o_dq = '0;
    end

    // Entered just after a K fall; one burst per two K rises
    task automatic xfer(input logic rw, input logic [bdsp_pkg::ADDR_W-1:0] a,
                        input logic [bdsp_pkg::LINE_W-1:0] d, input logic hold);
        o_load_n = 1'b0;
        o_read_nwrite = rw;
        o_addr = a;
        // Changes land 1 ns after an edge, clear of both samplers
        @(negedge i_k_clk);
        #1;
        // Hold turns the second rise into a write that must be dropped
        o_load_n = ~hold;
        o_read_nwrite = ~rw;
        o_addr = ~a;
        if (!rw) o_dq = d[bdsp_pkg::DATA_W-1:0];
        @(posedge i_k_clk);
        #1;
        o_load_n = 1'b1;
        if (!rw) o_dq = d[bdsp_pkg::LINE_W-1:bdsp_pkg::DATA_W];
        @(negedge i_k_clk);
        #1;
        o_dq = ~o_dq;
    endtask : xfer
endmodule : bdsp_ctrl_model

/* tb/bdsp_port_sva.sv */
// Port checker for the burst memory port
`timescale 1ns/1ps

module bdsp_port_sva (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_k_clk,
    input wire logic i_kn_clk,
    input wire logic i_load_n,
    input wire logic i_read_nwrite,
    input wire logic i_pll_latency_select,
    input wire logic [bdsp_pkg::DATA_W-1:0] o_dq_k,
    input wire logic o_dq_oe_k,
    input wire logic o_read_valid_flag_k,
    input wire logic o_read_valid_flag_kn,
    input wire logic [1:0] o_echo_clock_pair_k,
    input wire logic o_write_done
);
    // ==========================================================
    // Link timing
    // ==========================================================
    lat_pll_a: assert property (@(posedge i_k_clk) disable iff (!i_rst_n)
        !i_load_n && $past(i_load_n) && i_read_nwrite && i_pll_latency_select
        |-> ##2 !o_read_valid_flag_k ##1 o_read_valid_flag_k) else $error("pll read latency wrong");
    lat_legacy_a: assert property (@(posedge i_k_clk) disable iff (!i_rst_n)
        !i_load_n && $past(i_load_n) && i_read_nwrite && !i_pll_latency_select
        |-> ##1 !o_read_valid_flag_k ##1 o_read_valid_flag_k) else $error("legacy read latency wrong");
    write_quiet_a: assert property (@(posedge i_k_clk) disable iff (!i_rst_n)
        !i_load_n && $past(i_load_n) && !i_read_nwrite |-> ##2 !o_read_valid_flag_k [*2])
        else $error("read data after write");
    burst_pair_a: assert property (@(posedge i_k_clk) disable iff (!i_rst_n)
        o_read_valid_flag_k |-> o_read_valid_flag_kn ##1 !o_read_valid_flag_k) else $error("burst not two words");
    valid_oe_a: assert property (@(posedge i_kn_clk) disable iff (!i_rst_n)
        o_read_valid_flag_k == o_dq_oe_k) else $error("valid and drive differ");
    idle_zero_a: assert property (@(posedge i_kn_clk) disable iff (!i_rst_n)
        !o_read_valid_flag_k |-> o_dq_k == bdsp_pkg::DQ_IDLE) else $error("data not idle");
    echo_align_a: assert property (@(posedge i_kn_clk) disable iff (!i_rst_n)
        o_read_valid_flag_k |-> o_echo_clock_pair_k == bdsp_pkg::ECHO_AFTER_K) else $error("echo misaligned");
    done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_write_done |=> !o_write_done) else $error("write done too long");
    cover property (@(posedge i_k_clk) i_pll_latency_select && o_read_valid_flag_k);
    cover property (@(posedge i_k_clk) !i_pll_latency_select && o_read_valid_flag_k);
    cover property (@(posedge i_clk) o_write_done);
endmodule : bdsp_port_sva

/* tb/tb_top.sv */
// Self-checking bench for the burst memory port
`timescale 1ns/1ps

module tb_top;
    localparam int LW = bdsp_pkg::LINE_W;
    logic i_clk, i_k_clk, i_kn_clk, i_rst_n, i_load_n, i_read_nwrite, i_pll_latency_select;
    logic [bdsp_pkg::ADDR_W-1:0] i_addr, a;
    logic [bdsp_pkg::DATA_W-1:0] i_dq, o_dq_k, o_dq_kn;
    logic o_dq_oe_k, o_dq_oe_kn, o_read_valid_flag_k, o_read_valid_flag_kn, o_write_done, o_read_done;
    logic [1:0] o_echo_clock_pair_k, o_echo_clock_pair_kn;
    logic [LW-1:0] mem [int];
    logic [LW-1:0] exp_line [$];
    logic [LW-1:0] ln;
    int exp_due [$];
    int kcnt, mismatches, total_checks, nwr, nrd, wdone_cnt, rdone_cnt;

    assign i_kn_clk = ~i_k_clk;
    bdsp_ctrl_model bdsp_ctrl_model_i (.i_k_clk(i_k_clk), .o_load_n(i_load_n),
        .o_read_nwrite(i_read_nwrite), .o_addr(i_addr), .o_dq(i_dq));
    bdsp_port bdsp_port_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_k_clk(i_k_clk), .i_kn_clk(i_kn_clk),
        .i_load_n(i_load_n), .i_read_nwrite(i_read_nwrite), .i_addr(i_addr), .i_dq(i_dq),
        .i_pll_latency_select(i_pll_latency_select), .o_dq_k(o_dq_k), .o_dq_kn(o_dq_kn),
        .o_dq_oe_k(o_dq_oe_k), .o_dq_oe_kn(o_dq_oe_kn), .o_read_valid_flag_k(o_read_valid_flag_k),
        .o_read_valid_flag_kn(o_read_valid_flag_kn), .o_echo_clock_pair_k(o_echo_clock_pair_k),
        .o_echo_clock_pair_kn(o_echo_clock_pair_kn), .o_write_done(o_write_done), .o_read_done(o_read_done)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        i_k_clk = 1'b0;
        #3;
        forever #80 i_k_clk = ~i_k_clk;
    end
    always @(posedge i_k_clk) kcnt <= kcnt + 1;
    always @(posedge i_clk) begin
        if (o_write_done === 1'b1) wdone_cnt++;
        if (o_read_done === 1'b1) rdone_cnt++;
    end

    task automatic chk(input logic [LW-1:0] got, input logic [LW-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [bdsp_pkg::ADDR_W-1:0] wa, input logic [LW-1:0] d);
        mem[wa] = d;
        nwr++;
        bdsp_ctrl_model_i.xfer(1'b0, wa, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [bdsp_pkg::ADDR_W-1:0] ra, input logic hold);
        exp_line.push_back(mem[ra]);
        exp_due.push_back(kcnt + (i_pll_latency_select ? 3 : 2));
        nrd++;
        bdsp_ctrl_model_i.xfer(1'b1, ra, '0, hold);
    endtask : rd

    // ==========================================================
    // Read monitor
    // ==========================================================
    initial begin
        wait (i_rst_n === 1'b1);
        forever begin
            @(posedge i_k_clk);
            #1;
            if (o_read_valid_flag_k !== 1'b0) begin
                if (exp_line.size() == 0) begin
                    chk(LW'(o_read_valid_flag_k), '0);
                end else begin
                    ln = exp_line.pop_front();
                    chk(LW'(kcnt), LW'(exp_due.pop_front()));
                    chk(LW'(o_dq_k), LW'(ln[bdsp_pkg::DATA_W-1:0]));
                    chk(LW'(o_echo_clock_pair_k), LW'(bdsp_pkg::ECHO_AFTER_K));
                    @(posedge i_kn_clk);
                    #1;
                    chk(LW'(o_read_valid_flag_kn), LW'(1'b1));
                    chk(LW'(o_dq_oe_kn), LW'(1'b1));
                    chk(LW'(o_dq_kn), LW'(ln[LW-1:bdsp_pkg::DATA_W]));
                    chk(LW'(o_echo_clock_pair_kn), LW'(bdsp_pkg::ECHO_AFTER_KN));
                end
            end
        end
    end

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        mismatches++;
        test_done();
    end

    initial begin
        i_rst_n = 1'b0;
        i_pll_latency_select = 1'b1;
        void'($urandom(71));
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (5) @(negedge i_k_clk);
        wr('1, 36'hA5A5A5A5A);
        wr('0, 36'h123456789);
        for (int l = 1; l >= 0; l--) begin
            @(negedge i_clk);
            i_pll_latency_select = l[0];
            repeat (4) @(negedge i_k_clk);
            rd('1, 1'b1);
            rd('0, 1'b0);
            repeat (24) begin
                a = bdsp_pkg::ADDR_W'($urandom_range(0, 7));
                if (mem.exists(a) && $urandom_range(0, 1) == 1) rd(a, 1'b0);
                else wr(a, LW'({$urandom, $urandom}));
            end
        end
        repeat (8) @(negedge i_k_clk);
        chk(LW'(wdone_cnt), LW'(nwr));
        chk(LW'(rdone_cnt), LW'(nrd));
        chk(LW'(exp_line.size()), '0);
        test_done();
    end
endmodule : tb_top

bind bdsp_port bdsp_port_sva bdsp_port_sva_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_k_clk(i_k_clk), .i_kn_clk(i_kn_clk),
    .i_load_n(i_load_n), .i_read_nwrite(i_read_nwrite), .i_pll_latency_select(i_pll_latency_select),
    .o_dq_k(o_dq_k), .o_dq_oe_k(o_dq_oe_k), .o_read_valid_flag_k(o_read_valid_flag_k),
    .o_read_valid_flag_kn(o_read_valid_flag_kn), .o_echo_clock_pair_k(o_echo_clock_pair_k),
    .o_write_done(o_write_done)
);
